//--- core/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// Function
// - Pin event, power-on-clear reset or a read of the cause register clears it to zero.
// - Watchdog or undervoltage reset never clears the cause register; other flag holds.
// - Watchdog reset sets watchdog flag; undervoltage reset sets undervoltage flag.
// - Cause register: watchdog flag bit 4, undervoltage flag bit 0, rest zero.
// - Undervoltage mode and level registers clear on pin, power-clear, watchdog; hold else.
// - Option 0: hold reset until supply above 1.59 V; reassert when it drops.
// - Option 1: release at 2.7 V; reassert below 1.59 V; rerelease only at 2.7 V.
// - Reset loads interrupt mask and priority with FFH; requests and edge enables 00H.
// - Reset loads all serial bus interface registers with 00H.
// - Reset loads multiplier/divider remainder and operands 0000H, control 00H.
// - Reset loads LCD setup, display, clock, boost and key return mode 00H.
// - During reset only the program counter is undefined; the registers above load their reset values.

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define RSC_CAUSE_ADDR   16'hFFAC
`define RSC_UV_MODE_ADDR 16'hFFBE
`define RSC_UV_LVL_ADDR  16'hFFBF

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSC_WDT_BIT 4
`define RSC_UV_BIT  0

// ----------------------------------------------------------------------------
// Reset and init values
// ----------------------------------------------------------------------------
`define RSC_BYTE_ZERO  8'h00
`define RSC_BYTE_ONES  8'hFF
`define RSC_HWORD_ZERO 16'h0000
`define RSC_SB_ZERO    56'h00000000000000
`define RSC_LCD_ZERO   40'h0000000000

`endif

//--- core/rsc_pkg.sv
package rsc_pkg;

  // --------------------------------------------------------------------------
  // Power-on-clear sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_POC_STRAP,
    RSC_POC_HOLD,
    RSC_POC_RUN
  } rsc_poc_state_t;

endpackage

//--- core/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_sync
  import rsc_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  // --------------------------------------------------------------------------
  // Two-stage synchroniser per bit
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic stab_q;
      logic stab_d;
      always_comb begin
        meta_d = clk_en_in ? async_in[gi] : meta_q;
        stab_d = clk_en_in ? meta_q : stab_q;
      end
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q <= 1'b0;
          stab_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          stab_q <= stab_d;
        end
      end
      assign sync_out[gi] = stab_q;
    end
  endgenerate

endmodule

`default_nettype wire

//--- core/rsc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.svh"

module rsc_reset_ctrl
  import rsc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        reset_pin_n_in,
  input  wire logic        vdd_above_159_in,
  input  wire logic        vdd_above_27_in,
  input  wire logic        power_clear_threshold_option_in,
  input  wire logic        watchdog_reset_req_in,
  input  wire logic        undervoltage_reset_req_in,
  input  wire logic [15:0] bus_addr_in,
  input  wire logic        bus_rd_in,
  input  wire logic        bus_wr_in,
  input  wire logic [7:0]  bus_wdata_in,
  output var  logic [7:0]  bus_rdata_out,
  output var  logic        internal_reset_out,
  output var  logic        pc_undefined_out,
  output var  logic        power_on_clear_out,
  output var  logic [7:0]  reset_cause_flags_out,
  output var  logic [7:0]  undervoltage_mode_reg_out,
  output var  logic [7:0]  undervoltage_level_reg_out,
  output var  logic [7:0]  irq_request_flags_out,
  output var  logic [7:0]  irq_mask_flags_out,
  output var  logic [7:0]  irq_priority_flags_out,
  output var  logic [7:0]  ext_rise_edge_enable_out,
  output var  logic [7:0]  ext_fall_edge_enable_out,
  output var  logic [55:0] serial_bus_init_out,
  output var  logic [15:0] remainder_reg_out,
  output var  logic [15:0] muldiv_operand_a_out,
  output var  logic [15:0] muldiv_operand_b_out,
  output var  logic [7:0]  muldiv_control_out,
  output var  logic [39:0] lcd_init_out
);

  // --------------------------------------------------------------------------
  // Pin and comparator synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;
  logic       pin_req;
  logic       above_159;
  logic       above_27;

  assign pin_raw = {vdd_above_27_in, vdd_above_159_in, reset_pin_n_in};

  rsc_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clk_en_in  (clk_en_in),
    .async_in   (pin_raw),
    .sync_out   (pin_sync)
  );

  assign pin_req   = ~pin_sync[0];
  assign above_159 = pin_sync[1];
  assign above_27  = pin_sync[2];

  // --------------------------------------------------------------------------
  // Power-on-clear sequencer
  // --------------------------------------------------------------------------
  rsc_poc_state_t poc_state_q;
  rsc_poc_state_t poc_state_d;
  logic           poc_mode_q;
  logic           poc_mode_d;
  logic           poc_req;

  always_comb begin
    poc_state_d = poc_state_q;
    poc_mode_d  = poc_mode_q;
    if (clk_en_in) begin
      unique case (poc_state_q)
        RSC_POC_STRAP: begin
          poc_mode_d  = power_clear_threshold_option_in;
          poc_state_d = RSC_POC_HOLD;
        end
        RSC_POC_HOLD: begin
          if (!poc_mode_q && above_159) begin
            poc_state_d = RSC_POC_RUN;
          end
          if (poc_mode_q && above_27 && above_159) begin
            poc_state_d = RSC_POC_RUN;
          end
        end
        RSC_POC_RUN: begin
          if (!above_159) begin
            poc_state_d = RSC_POC_HOLD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      poc_state_q <= RSC_POC_STRAP;
      poc_mode_q  <= 1'b0;
    end else begin
      poc_state_q <= poc_state_d;
      poc_mode_q  <= poc_mode_d;
    end
  end

  assign poc_req = (poc_state_q != RSC_POC_RUN);

  // --------------------------------------------------------------------------
  // Reset merge
  // --------------------------------------------------------------------------
  logic any_req;
  logic clear_req;
  logic rst_out_q;
  logic rst_out_d;
  logic poc_out_q;
  logic poc_out_d;

  assign any_req   = pin_req | poc_req | watchdog_reset_req_in | undervoltage_reset_req_in;
  assign clear_req = pin_req | poc_req;

  always_comb begin
    rst_out_d = rst_out_q;
    poc_out_d = poc_out_q;
    if (clk_en_in) begin
      rst_out_d = any_req;
      poc_out_d = poc_req;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_out_q <= 1'b1;
      poc_out_q <= 1'b1;
    end else begin
      rst_out_q <= rst_out_d;
      poc_out_q <= poc_out_d;
    end
  end

  assign internal_reset_out = rst_out_q;
  assign pc_undefined_out   = rst_out_q;
  assign power_on_clear_out = poc_out_q;

  // --------------------------------------------------------------------------
  // Reset cause flags
  // --------------------------------------------------------------------------
  logic       wdt_flag_q;
  logic       wdt_flag_d;
  logic       uv_flag_q;
  logic       uv_flag_d;
  logic [7:0] cause_word;
  logic       cause_rd;

  assign cause_rd = bus_rd_in && (bus_addr_in == `RSC_CAUSE_ADDR);

  always_comb begin
    wdt_flag_d = wdt_flag_q;
    uv_flag_d  = uv_flag_q;
    if (clk_en_in) begin
      if (cause_rd) begin
        wdt_flag_d = 1'b0;
        uv_flag_d  = 1'b0;
      end
      if (watchdog_reset_req_in) begin
        wdt_flag_d = 1'b1;
      end
      if (undervoltage_reset_req_in) begin
        uv_flag_d = 1'b1;
      end
      if (clear_req) begin
        wdt_flag_d = 1'b0;
        uv_flag_d  = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdt_flag_q <= 1'b0;
      uv_flag_q  <= 1'b0;
    end else begin
      wdt_flag_q <= wdt_flag_d;
      uv_flag_q  <= uv_flag_d;
    end
  end

  always_comb begin
    cause_word               = `RSC_BYTE_ZERO;
    cause_word[`RSC_WDT_BIT] = wdt_flag_q;
    cause_word[`RSC_UV_BIT]  = uv_flag_q;
  end

  assign reset_cause_flags_out = cause_word;

  // --------------------------------------------------------------------------
  // Undervoltage detector settings
  // --------------------------------------------------------------------------
  logic [7:0] uv_mode_q;
  logic [7:0] uv_mode_d;
  logic [7:0] uv_lvl_q;
  logic [7:0] uv_lvl_d;
  logic       uv_clear;

  assign uv_clear = pin_req | poc_req | watchdog_reset_req_in;

  always_comb begin
    uv_mode_d = uv_mode_q;
    uv_lvl_d  = uv_lvl_q;
    if (clk_en_in) begin
      if (bus_wr_in && !any_req && (bus_addr_in == `RSC_UV_MODE_ADDR)) begin
        uv_mode_d = bus_wdata_in;
      end
      if (bus_wr_in && !any_req && (bus_addr_in == `RSC_UV_LVL_ADDR)) begin
        uv_lvl_d = bus_wdata_in;
      end
      if (uv_clear) begin
        uv_mode_d = `RSC_BYTE_ZERO;
        uv_lvl_d  = `RSC_BYTE_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      uv_mode_q <= `RSC_BYTE_ZERO;
      uv_lvl_q  <= `RSC_BYTE_ZERO;
    end else begin
      uv_mode_q <= uv_mode_d;
      uv_lvl_q  <= uv_lvl_d;
    end
  end

  assign undervoltage_mode_reg_out  = uv_mode_q;
  assign undervoltage_level_reg_out = uv_lvl_q;

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (clk_en_in && bus_rd_in) begin
      unique case (bus_addr_in)
        `RSC_CAUSE_ADDR:   rdata_d = cause_word;
        `RSC_UV_MODE_ADDR: rdata_d = uv_mode_q;
        `RSC_UV_LVL_ADDR:  rdata_d = uv_lvl_q;
        default:           rdata_d = `RSC_BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= `RSC_BYTE_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign bus_rdata_out = rdata_q;

  // --------------------------------------------------------------------------
  // Peripheral init images
  // --------------------------------------------------------------------------
  localparam logic [191:0] INIT_IMAGE = {
    `RSC_BYTE_ZERO, `RSC_BYTE_ONES, `RSC_BYTE_ONES, `RSC_BYTE_ZERO, `RSC_BYTE_ZERO,
    `RSC_SB_ZERO,
    `RSC_HWORD_ZERO, `RSC_HWORD_ZERO, `RSC_HWORD_ZERO, `RSC_BYTE_ZERO,
    `RSC_LCD_ZERO
  };

  logic [191:0] init_q;
  logic [191:0] init_d;

  always_comb begin
    init_d = init_q;
    if (clk_en_in && any_req) begin
      init_d = INIT_IMAGE;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      init_q <= INIT_IMAGE;
    end else begin
      init_q <= init_d;
    end
  end

  assign {irq_request_flags_out, irq_mask_flags_out, irq_priority_flags_out,
          ext_rise_edge_enable_out, ext_fall_edge_enable_out, serial_bus_init_out,
          remainder_reg_out, muldiv_operand_a_out, muldiv_operand_b_out,
          muldiv_control_out, lcd_init_out} = init_q;

endmodule

`default_nettype wire

//--- tb/rsc_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_supply_model
  import rsc_pkg::*;
#(
  parameter int UV_MV = 12'h708
) (
  input  wire logic [11:0] vdd_mv_in,
  input  wire logic        uv_arm_in,
  output var  logic        above_159_out,
  output var  logic        above_27_out,
  output var  logic        uv_req_out
);
  // ---------------------------------------------------------------------
  // Comparators: 1590 mV and 2700 mV, detector level in mV
  // ---------------------------------------------------------------------
  assign above_159_out = vdd_mv_in >= 12'h636;
  assign above_27_out  = vdd_mv_in >= 12'hA8C;
  assign uv_req_out    = uv_arm_in && (vdd_mv_in < UV_MV);
endmodule

`default_nettype wire

//--- tb/rsc_reset_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_chk
  import rsc_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        clk_en_in,
  input wire logic        reset_pin_n_in,
  input wire logic        watchdog_reset_req_in,
  input wire logic        undervoltage_reset_req_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic        bus_rd_in,
  input wire logic [7:0]  bus_rdata_out,
  input wire logic        internal_reset_out,
  input wire logic        pc_undefined_out,
  input wire logic        power_on_clear_out,
  input wire logic [7:0]  reset_cause_flags_out,
  input wire logic [7:0]  undervoltage_mode_reg_out,
  input wire logic [7:0]  irq_mask_flags_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_c = clk_en_in && bus_rd_in && (bus_addr_in == 16'hFFAC);
  wire src  = watchdog_reset_req_in || undervoltage_reset_req_in;

  chk_flag_bits: assert property ((reset_cause_flags_out & 8'hEE) == 8'h00)
    else $error("spare cause bits set");
  chk_pc_follow: assert property (pc_undefined_out == internal_reset_out)
    else $error("pc flag differs from reset");
  chk_poc_reset: assert property (power_on_clear_out |-> internal_reset_out)
    else $error("power clear without reset");
  chk_src_reset: assert property (clk_en_in && src |=> internal_reset_out)
    else $error("request without reset");
  chk_wdt_flag: assert property ((reset_pin_n_in && !power_on_clear_out)[*4] ##0
    (clk_en_in && watchdog_reset_req_in) |=> reset_cause_flags_out[4])
    else $error("watchdog flag not set");
  chk_read_clear: assert property (rd_c && !src |=> reset_cause_flags_out == 8'h00)
    else $error("read did not clear");
  chk_read_data: assert property (rd_c |=> bus_rdata_out == $past(reset_cause_flags_out))
    else $error("read data wrong");
  chk_uv_clear: assert property (clk_en_in && watchdog_reset_req_in
    |=> undervoltage_mode_reg_out == 8'h00)
    else $error("mode reg kept on watchdog");
  chk_irq_init: assert property (internal_reset_out |-> irq_mask_flags_out == 8'hFF)
    else $error("mask not loaded");

  cover property (rd_c);
  cover property (clk_en_in && watchdog_reset_req_in);
  cover property ($fell(internal_reset_out));
endmodule

bind rsc_reset_ctrl rsc_chk u_chk (
  .clk_sys_in                (clk_sys_in),
  .rst_n_in                  (rst_n_in),
  .clk_en_in                 (clk_en_in),
  .reset_pin_n_in            (reset_pin_n_in),
  .watchdog_reset_req_in     (watchdog_reset_req_in),
  .undervoltage_reset_req_in (undervoltage_reset_req_in),
  .bus_addr_in               (bus_addr_in),
  .bus_rd_in                 (bus_rd_in),
  .bus_rdata_out             (bus_rdata_out),
  .internal_reset_out        (internal_reset_out),
  .pc_undefined_out          (pc_undefined_out),
  .power_on_clear_out        (power_on_clear_out),
  .reset_cause_flags_out     (reset_cause_flags_out),
  .undervoltage_mode_reg_out (undervoltage_mode_reg_out),
  .irq_mask_flags_out        (irq_mask_flags_out)
);

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import rsc_pkg::*;
;
  logic        clk_sys_in, rst_n_in, clk_en_in, reset_pin_n_in;
  logic        power_clear_threshold_option_in, vdd_above_159_in, vdd_above_27_in;
  logic        watchdog_reset_req_in, undervoltage_reset_req_in, bus_rd_in, bus_wr_in;
  logic        internal_reset_out, pc_undefined_out, power_on_clear_out, uv_arm;
  logic [15:0] bus_addr_in, remainder_reg_out, muldiv_operand_a_out, muldiv_operand_b_out;
  logic [11:0] vdd_mv;
  logic [7:0]  bus_wdata_in, bus_rdata_out, reset_cause_flags_out, rd_v, muldiv_control_out;
  logic [7:0]  undervoltage_mode_reg_out, undervoltage_level_reg_out, irq_request_flags_out;
  logic [7:0]  irq_mask_flags_out, irq_priority_flags_out;
  logic [7:0]  ext_rise_edge_enable_out, ext_fall_edge_enable_out;
  logic [55:0] serial_bus_init_out;
  logic [39:0] lcd_init_out;
  int          mismatches, comparisons;

  rsc_supply_model sup (
    .vdd_mv_in     (vdd_mv),
    .uv_arm_in     (uv_arm),
    .above_159_out (vdd_above_159_in),
    .above_27_out  (vdd_above_27_in),
    .uv_req_out    (undervoltage_reset_req_in)
  );
  rsc_reset_ctrl dut (
    .clk_sys_in                      (clk_sys_in),
    .rst_n_in                        (rst_n_in),
    .clk_en_in                       (clk_en_in),
    .reset_pin_n_in                  (reset_pin_n_in),
    .vdd_above_159_in                (vdd_above_159_in),
    .vdd_above_27_in                 (vdd_above_27_in),
    .power_clear_threshold_option_in (power_clear_threshold_option_in),
    .watchdog_reset_req_in           (watchdog_reset_req_in),
    .undervoltage_reset_req_in       (undervoltage_reset_req_in),
    .bus_addr_in                     (bus_addr_in),
    .bus_rd_in                       (bus_rd_in),
    .bus_wr_in                       (bus_wr_in),
    .bus_wdata_in                    (bus_wdata_in),
    .bus_rdata_out                   (bus_rdata_out),
    .internal_reset_out              (internal_reset_out),
    .pc_undefined_out                (pc_undefined_out),
    .power_on_clear_out              (power_on_clear_out),
    .reset_cause_flags_out           (reset_cause_flags_out),
    .undervoltage_mode_reg_out       (undervoltage_mode_reg_out),
    .undervoltage_level_reg_out      (undervoltage_level_reg_out),
    .irq_request_flags_out           (irq_request_flags_out),
    .irq_mask_flags_out              (irq_mask_flags_out),
    .irq_priority_flags_out          (irq_priority_flags_out),
    .ext_rise_edge_enable_out        (ext_rise_edge_enable_out),
    .ext_fall_edge_enable_out        (ext_fall_edge_enable_out),
    .serial_bus_init_out             (serial_bus_init_out),
    .remainder_reg_out               (remainder_reg_out),
    .muldiv_operand_a_out            (muldiv_operand_a_out),
    .muldiv_operand_b_out            (muldiv_operand_b_out),
    .muldiv_control_out              (muldiv_control_out),
    .lcd_init_out                    (lcd_init_out)
  );

  initial begin
    clk_sys_in = 1'h0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #10;
  endtask

  task automatic bus(input logic [15:0] a, input logic w, input logic [7:0] d);
    bus_addr_in = a;
    bus_wr_in = w;
    bus_rd_in = !w;
    bus_wdata_in = d;
    cyc(1);
    rd_v = bus_rdata_out;
    bus_rd_in = 1'h0;
    bus_wr_in = 1'h0;
    cyc(1);
  endtask

  task automatic wait_rst(input logic lvl);
    for (int i = 0; i < 20 && internal_reset_out !== lvl; i++) cyc(1);
    if (internal_reset_out !== lvl) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic do_reset(input logic o);
    rst_n_in = 1'h0;
    power_clear_threshold_option_in = o;
    cyc(12);
    rst_n_in = 1'h1;
  endtask

  task automatic wdt_pulse();
    watchdog_reset_req_in = 1'h1;
    cyc(1);
    watchdog_reset_req_in = 1'h0;
    chk(internal_reset_out, 1'h1);
    chk(pc_undefined_out, 1'h1);
    wait_rst(1'h0);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_opt0();
    do_reset(1'h0);
    cyc(10);
    chk(internal_reset_out, 1'h1);
    vdd_mv = 12'h6A4;
    wait_rst(1'h0);
    chk(reset_cause_flags_out, 8'h00);
    chk({irq_mask_flags_out, irq_priority_flags_out, irq_request_flags_out,
         ext_rise_edge_enable_out, ext_fall_edge_enable_out}, 40'hFFFF000000);
    chk(serial_bus_init_out, 56'h0);
    chk({remainder_reg_out, muldiv_operand_a_out, muldiv_operand_b_out,
         muldiv_control_out}, 56'h0);
    chk(lcd_init_out, 40'h0);
    vdd_mv = 12'h5DC;
    wait_rst(1'h1);
    chk(power_on_clear_out, 1'h1);
    vdd_mv = 12'h6A4;
    wait_rst(1'h0);
  endtask

  task automatic t_causes();
    vdd_mv = 12'h7D0;
    bus(16'hFFBE, 1'h1, 8'h5A);
    bus(16'hFFBF, 1'h1, 8'hA5);
    uv_arm = 1'h1;
    vdd_mv = 12'h6A4;
    cyc(1);
    uv_arm = 1'h0;
    chk(internal_reset_out, 1'h1);
    wait_rst(1'h0);
    chk(reset_cause_flags_out, 8'h01);
    chk({undervoltage_mode_reg_out, undervoltage_level_reg_out}, 16'h5AA5);
    vdd_mv = 12'h7D0;
    wdt_pulse();
    chk(reset_cause_flags_out, 8'h11);
    chk({undervoltage_mode_reg_out, undervoltage_level_reg_out}, 16'h0000);
    bus(16'hFFAC, 1'h1, 8'hFF);
    chk(reset_cause_flags_out, 8'h11);
    bus(16'hFFAC, 1'h0, 8'h00);
    chk(rd_v, 8'h11);
    chk(reset_cause_flags_out, 8'h00);
    bus(16'hFFAD, 1'h0, 8'h00);
    chk(rd_v, 8'h00);
    clk_en_in = 1'h0;
    watchdog_reset_req_in = 1'h1;
    cyc(3);
    chk(internal_reset_out, 1'h0);
    chk(reset_cause_flags_out, 8'h00);
    watchdog_reset_req_in = 1'h0;
    clk_en_in = 1'h1;
    cyc(1);
  endtask

  task automatic t_pin();
    wdt_pulse();
    bus(16'hFFBF, 1'h1, 8'h3C);
    reset_pin_n_in = 1'h0;
    cyc(4);
    chk(internal_reset_out, 1'h1);
    reset_pin_n_in = 1'h1;
    wait_rst(1'h0);
    chk(reset_cause_flags_out, 8'h00);
    chk(undervoltage_level_reg_out, 8'h00);
  endtask

  task automatic t_opt1();
    do_reset(1'h1);
    cyc(20);
    chk(internal_reset_out, 1'h1);
    vdd_mv = 12'hAF0;
    wait_rst(1'h0);
    vdd_mv = 12'h7D0;
    cyc(20);
    chk(internal_reset_out, 1'h0);
    vdd_mv = 12'h5DC;
    wait_rst(1'h1);
    vdd_mv = 12'h7D0;
    cyc(20);
    chk(internal_reset_out, 1'h1);
    vdd_mv = 12'hAF0;
    wait_rst(1'h0);
  endtask

  initial begin
    mismatches = 0;
    comparisons = 0;
    rst_n_in = 1'h0;
    clk_en_in = 1'h1;
    reset_pin_n_in = 1'h1;
    power_clear_threshold_option_in = 1'h0;
    watchdog_reset_req_in = 1'h0;
    uv_arm = 1'h0;
    vdd_mv = 12'h000;
    bus_addr_in = 16'h0000;
    bus_rd_in = 1'h0;
    bus_wr_in = 1'h0;
    bus_wdata_in = 8'h00;
    rd_v = 8'h00;
    t_opt0();
    t_causes();
    t_pin();
    t_opt1();
    tally_and_finish();
  end
endmodule

`default_nettype wire
